// File: rtl/rcd_config_decoder.sv
// receiver configuration word decoder: two configuration registers and their decoded settings
module rcd_config_decoder
  import rcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        frame_start,
  input  wire logic        bit_stb,
  input  wire logic        data_in,
  input  wire logic        supply_dip,
  output logic             data_out,
  output logic             data_oe,
  output logic             off_cmd,
  output logic             supply_loss_marker,
  output logic [1:0]       rate_band_select,
  output logic [3:0]       limit_scale_factor,
  output logic [3:0]       check_bit_count,
  output logic             modulation_select,
  output logic [4:0]       idle_code,
  output logic             idle_stretch,
  output logic             noise_gate_en,
  output logic [9:0]       lim_min_cyc,
  output logic [9:0]       lim_max_cyc,
  output logic [17:0]      idle_cycles,
  output logic             poll_continuous,
  output logic             idle_permanent
);

  logic        off_stb;
  logic        wr_stb;
  logic        wr_sel;
  logic [11:0] wr_data;

  rcd_word_shifter u_shift (
    .clk         (clk),
    .rstn        (rstn),
    .clk_en      (clk_en),
    .frame_start (frame_start),
    .bit_stb     (bit_stb),
    .data_in     (data_in),
    .off_stb     (off_stb),
    .wr_stb      (wr_stb),
    .wr_sel      (wr_sel),
    .wr_data     (wr_data)
  );

  // configuration registers
  logic [11:0] opcfg_q, opcfg_d;
  logic [11:0] window_q, window_d;
  logic        wr_op, wr_win;

  always_comb begin
    wr_op    = wr_stb && (wr_sel == SEL_OPCFG);
    wr_win   = wr_stb && (wr_sel == SEL_WINDOW);
    opcfg_d  = opcfg_q;
    window_d = window_q;
    if (wr_op) begin
      opcfg_d = wr_data;
    end
    if (wr_win) begin
      window_d = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opcfg_q  <= OPCFG_RST;
      window_q <= WINDOW_RST;
    end else if (clk_en) begin
      opcfg_q  <= opcfg_d;
      window_q <= window_d;
    end
  end

  // supply-loss marker; the flag only drops once both registers were rewritten
  logic       mark_q, mark_d;
  logic       op_rw_q, op_rw_d;
  logic       win_rw_q, win_rw_d;
  logic [7:0] pat_q, pat_d;
  logic       oe_q, oe_d;
  logic       off_q, off_d;

  always_comb begin
    op_rw_d  = op_rw_q || wr_op;
    win_rw_d = win_rw_q || wr_win;
    mark_d   = mark_q;
    if (mark_q && op_rw_d && win_rw_d) begin
      mark_d = 1'b0;
    end
    if (!mark_d) begin
      op_rw_d  = 1'b0;
      win_rw_d = 1'b0;
    end
    // a dip in the same cycle as the last rewrite still wins
    if (supply_dip) begin
      mark_d   = 1'b1;
      op_rw_d  = 1'b0;
      win_rw_d = 1'b0;
    end
    pat_d = mark_q ? {pat_q[6:0], pat_q[7]} : MARK_PATTERN;
    oe_d  = mark_q && !pat_q[7];
    off_d = off_stb;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mark_q   <= 1'b0;
      op_rw_q  <= 1'b0;
      win_rw_q <= 1'b0;
      pat_q    <= MARK_PATTERN;
      oe_q     <= 1'b0;
      off_q    <= 1'b0;
    end else if (clk_en) begin
      mark_q   <= mark_d;
      op_rw_q  <= op_rw_d;
      win_rw_q <= win_rw_d;
      pat_q    <= pat_d;
      oe_q     <= oe_d;
      off_q    <= off_d;
    end
  end

  // open drain: the pin is only ever pulled low, a pull-up gives the high bits
  assign data_out           = 1'b0;
  assign data_oe            = oe_q;
  assign off_cmd            = off_q;
  assign supply_loss_marker = mark_q;

  // decoded settings, one register stage behind the configuration words
  logic [1:0]  rb_q, rb_d;
  logic [3:0]  scale_q, scale_d;
  logic [3:0]  chk_q, chk_d;
  logic        mod_q, mod_d;
  logic [4:0]  icode_q, icode_d;
  logic        istr_q, istr_d;
  logic        ng_q, ng_d;
  logic [9:0]  lmin_q, lmin_d;
  logic [9:0]  lmax_q, lmax_d;
  logic [17:0] idle_q, idle_d;
  logic        pcont_q, pcont_d;
  logic        pperm_q, pperm_d;
  logic [3:0]  stretch;

  always_comb begin
    rb_d    = opcfg_q[RB_MSB:RB_LSB];
    chk_d   = CHECK_C0;
    scale_d = SCALE_B0;
    case (rb_d)
      2'b00:   scale_d = SCALE_B0;
      2'b01:   scale_d = SCALE_B1;
      2'b10:   scale_d = SCALE_B2;
      2'b11:   scale_d = SCALE_B3;
      default: scale_d = SCALE_B0;
    endcase
    case (opcfg_q[CC_MSB:CC_LSB])
      2'b00:   chk_d = CHECK_C0;
      2'b01:   chk_d = CHECK_C1;
      2'b10:   chk_d = CHECK_C2;
      2'b11:   chk_d = CHECK_C3;
      default: chk_d = CHECK_C0;
    endcase
    mod_d   = opcfg_q[MOD_BIT];
    icode_d = opcfg_q[IDLE_MSB:IDLE_LSB];
    istr_d  = opcfg_q[STR_BIT];
    ng_d    = opcfg_q[NG_BIT];
    stretch = istr_d ? STRETCH_X8 : STRETCH_X1;
    lmin_d  = 10'(window_q[LMIN_MSB:LMIN_LSB] * scale_d);
    lmax_d  = 10'(window_q[LMAX_MSB:LMAX_LSB] * scale_d);
    idle_d  = 18'(icode_d * stretch * IDLE_UNIT_CYC);
    pcont_d = (icode_d == IDLE_CONT);
    pperm_d = (icode_d == IDLE_PERM);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rb_q    <= 2'b00;
      scale_q <= SCALE_B0;
      chk_q   <= CHECK_C0;
      mod_q   <= 1'b0;
      icode_q <= 5'h00;
      istr_q  <= 1'b0;
      ng_q    <= 1'b0;
      lmin_q  <= 10'h000;
      lmax_q  <= 10'h000;
      idle_q  <= 18'h00000;
      pcont_q <= 1'b0;
      pperm_q <= 1'b0;
    end else if (clk_en) begin
      rb_q    <= rb_d;
      scale_q <= scale_d;
      chk_q   <= chk_d;
      mod_q   <= mod_d;
      icode_q <= icode_d;
      istr_q  <= istr_d;
      ng_q    <= ng_d;
      lmin_q  <= lmin_d;
      lmax_q  <= lmax_d;
      idle_q  <= idle_d;
      pcont_q <= pcont_d;
      pperm_q <= pperm_d;
    end
  end

  assign rate_band_select   = rb_q;
  assign limit_scale_factor = scale_q;
  assign check_bit_count    = chk_q;
  assign modulation_select  = mod_q;
  assign idle_code          = icode_q;
  assign idle_stretch       = istr_q;
  assign noise_gate_en      = ng_q;
  assign lim_min_cyc        = lmin_q;
  assign lim_max_cyc        = lmax_q;
  assign idle_cycles        = idle_q;
  assign poll_continuous    = pcont_q;
  assign idle_permanent     = pperm_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  cmd_no_write_a: assert property (clk_en && off_stb |=> $stable(opcfg_q) && $stable(window_q))
    else $error("command word changed a register");

  op_write_a: assert property (clk_en && wr_stb && wr_sel
      |=> opcfg_q == $past(wr_data) && $stable(window_q))
    else $error("operating config write did not land");

  win_write_a: assert property (clk_en && wr_stb && !wr_sel
      |=> window_q == $past(wr_data) && $stable(opcfg_q))
    else $error("window write did not land");

  reg_hold_a: assert property (!(clk_en && wr_stb) |=> $stable(opcfg_q) && $stable(window_q))
    else $error("register changed without a committed word");

  scale_map_a: assert property (clk_en && opcfg_q[RB_MSB:RB_LSB] == 2'b00 |=> limit_scale_factor == 4'h8)
    else $error("rate band 00 did not give scale 8");

  lim_mult_a: assert property (clk_en
      |=> lim_max_cyc == 10'($past(window_q[LMAX_MSB:LMAX_LSB]) * limit_scale_factor))
    else $error("upper limit is not bound times scale");

  check_map_a: assert property (clk_en && opcfg_q[CC_MSB:CC_LSB] == 2'b11 |=> check_bit_count == 4'h9)
    else $error("check code 11 did not give 9 bits");

  idle_calc_a: assert property (clk_en && opcfg_q[STR_BIT]
      |=> idle_cycles == 18'(idle_code * 8 * 1024))
    else $error("stretched idle time is wrong");

  marker_set_a: assert property (clk_en && supply_dip |=> supply_loss_marker ##1 1'b1)
    else $error("supply dip did not raise the marker");

  marker_pin_a: assert property (clk_en && !supply_loss_marker |=> !data_oe)
    else $error("data pin pulled low without a marker");

  marker_hold_a: assert property (supply_loss_marker && !(clk_en && wr_stb)
      |=> supply_loss_marker)
    else $error("marker dropped without a rewrite");

  off_pulse_a: assert property (clk_en && off_stb |=> off_cmd)
    else $error("command word gave no return-to-polling pulse");

  band_map_a: assert property (clk_en |=> rate_band_select == $past(opcfg_q[RB_MSB:RB_LSB]))
    else $error("rate band field is not taken from bits 3 and 4");

  mod_map_a: assert property (clk_en |=> modulation_select == $past(opcfg_q[MOD_BIT]))
    else $error("modulation select does not follow its bit");

  gate_map_a: assert property (clk_en |=> noise_gate_en == $past(opcfg_q[NG_BIT]))
    else $error("noise gate does not follow its bit");

  lmin_mult_a: assert property (clk_en
      |=> lim_min_cyc == 10'($past(window_q[LMIN_MSB:LMIN_LSB]) * limit_scale_factor))
    else $error("lower limit is not bound times scale");

  idle_flat_a: assert property (clk_en && !opcfg_q[STR_BIT]
      |=> idle_cycles == 18'(idle_code * 1024))
    else $error("unstretched idle time is wrong");

  idle_ends_a: assert property (clk_en
      |=> poll_continuous == (idle_code == 5'h00) && idle_permanent == (idle_code == 5'h1F))
    else $error("continuous or permanent idle flag is wrong");

  cov_op_write:  cover property (clk_en && wr_stb && wr_sel);
  cov_win_write: cover property (clk_en && wr_stb && !wr_sel);
  cov_off_cmd:   cover property (off_cmd);
  cov_marker:    cover property (supply_loss_marker ##1 !supply_loss_marker);
  cov_dip_drive: cover property (supply_loss_marker && data_oe);

endmodule : rcd_config_decoder

// File: shared/rcd_pkg.sv
// constants and types shared by the receiver configuration word decoder
package rcd_pkg;

  localparam int          WORD_BITS  = 15;
  localparam int          FIELD_W    = 12;
  localparam logic [3:0]  STOP_CNT   = 4'(WORD_BITS - 1);

  // reset values of the two configuration registers
  localparam logic [11:0] OPCFG_RST  = 12'h119;
  localparam logic [11:0] WINDOW_RST = 12'h569;

  // word-to-register selection carried by the second bit
  localparam logic        SEL_OPCFG  = 1'b1;
  localparam logic        SEL_WINDOW = 1'b0;

  // operating configuration fields, bit 3 of the word lands at index 11
  localparam int RB_MSB   = 11;
  localparam int RB_LSB   = 10;
  localparam int CC_MSB   = 9;
  localparam int CC_LSB   = 8;
  localparam int MOD_BIT  = 7;
  localparam int IDLE_MSB = 6;
  localparam int IDLE_LSB = 2;
  localparam int STR_BIT  = 1;
  localparam int NG_BIT   = 0;

  // bit-check window fields
  localparam int LMIN_MSB = 11;
  localparam int LMIN_LSB = 6;
  localparam int LMAX_MSB = 5;
  localparam int LMAX_LSB = 0;

  // rate band to limit scale factor, check bit count codes
  localparam logic [3:0] SCALE_B0 = 4'h8;
  localparam logic [3:0] SCALE_B1 = 4'h4;
  localparam logic [3:0] SCALE_B2 = 4'h2;
  localparam logic [3:0] SCALE_B3 = 4'h1;
  localparam logic [3:0] CHECK_C0 = 4'h0;
  localparam logic [3:0] CHECK_C1 = 4'h3;
  localparam logic [3:0] CHECK_C2 = 4'h6;
  localparam logic [3:0] CHECK_C3 = 4'h9;

  // idle interval arithmetic
  localparam int         IDLE_UNIT_CYC = 1024;
  localparam logic [3:0] STRETCH_X1    = 4'h1;
  localparam logic [3:0] STRETCH_X8    = 4'h8;
  localparam logic [4:0] IDLE_CONT     = 5'h00;
  localparam logic [4:0] IDLE_PERM     = 5'h1F;

  // supply-loss marker shifted out on the data pin, msb first
  localparam logic [7:0] MARK_PATTERN  = 8'hA5;

  typedef enum logic [1:0] {
    RCD_WAIT  = 2'b00,
    RCD_SHIFT = 2'b01,
    RCD_SKIP  = 2'b10
  } rcd_state_t;

endpackage : rcd_pkg

// File: rtl/rcd_word_shifter.sv
// serial collector for 15-bit programming words
module rcd_word_shifter
  import rcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        frame_start,
  input  wire logic        bit_stb,
  input  wire logic        data_in,
  output logic             off_stb,
  output logic             wr_stb,
  output logic             wr_sel,
  output logic [11:0]      wr_data
);

  rcd_state_t  state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [13:0] sh_q, sh_d;
  logic        off_q, off_d, wr_q, wr_d, sel_q, sel_d;
  logic [11:0] data_q, data_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    off_d   = 1'b0;
    wr_d    = 1'b0;
    sel_d   = sel_q;
    data_d  = data_q;
    if (frame_start) begin
      // realign on a fresh word, a partial word is dropped
      state_d = RCD_WAIT;
      cnt_d   = 4'h0;
    end else if (bit_stb) begin
      cnt_d = cnt_q + 4'h1;
      case (state_q)
        RCD_WAIT: begin
          if (data_in) begin
            off_d   = 1'b1;
            state_d = RCD_SKIP;
          end else begin
            state_d = RCD_SHIFT;
          end
          sh_d  = {13'h0000, data_in};
          cnt_d = 4'h1;
        end
        RCD_SHIFT: begin
          sh_d = {sh_q[12:0], data_in};
          if (cnt_q == STOP_CNT) begin
            state_d = RCD_WAIT;
            cnt_d   = 4'h0;
            if (!data_in) begin
              wr_d   = 1'b1;
              sel_d  = sh_q[12];
              data_d = sh_q[11:0];
            end
          end
        end
        RCD_SKIP: begin
          if (cnt_q == STOP_CNT) begin
            state_d = RCD_WAIT;
            cnt_d   = 4'h0;
          end
        end
        default: begin
          state_d = RCD_WAIT;
          cnt_d   = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RCD_WAIT;
      cnt_q   <= 4'h0;
      sh_q    <= 14'h0000;
      off_q   <= 1'b0;
      wr_q    <= 1'b0;
      sel_q   <= 1'b0;
      data_q  <= 12'h000;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      off_q   <= off_d;
      wr_q    <= wr_d;
      sel_q   <= sel_d;
      data_q  <= data_d;
    end
  end

  assign off_stb = off_q;
  assign wr_stb  = wr_q;
  assign wr_sel  = sel_q;
  assign wr_data = data_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  stop_gate_a: assert property (clk_en && $past(clk_en) && wr_q |-> !$past(data_in))
    else $error("write committed although stop bit was high");
  off_excl_a: assert property (off_q |-> !wr_q)
    else $error("command word and register write in one cycle");

endmodule : rcd_word_shifter

// File: test/rcd_mcu_model.sv
// microcontroller side model: shifts programming words onto the serial input
module rcd_mcu_model (
  input  wire logic clk,
  output logic      frame_start,
  output logic      bit_stb,
  output logic      data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frame_start = 1'b0;
    bit_stb     = 1'b0;
    data_in     = 1'b1;
  end

  // w[14] goes out first; nbits below 15 abandons the word part way
  task automatic send(input logic [14:0] w, input int gap, input int nbits);
    @(posedge clk);
    #1;
    frame_start = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk);
      #1;
      frame_start = 1'b0;
      bit_stb     = 1'b1;
      data_in     = w[14 - i];
      repeat (gap) begin
        @(posedge clk);
        #1;
        bit_stb = 1'b0;
        // a released line must not keep showing the bit just sent
        data_in = ~data_in;
      end
    end
    @(posedge clk);
    #1;
    frame_start = 1'b0;
    bit_stb     = 1'b0;
    data_in     = ~data_in;
  endtask : send
endmodule : rcd_mcu_model

// File: test/tb.sv
// self-checking bench for the receiver configuration word decoder
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module tb import rcd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rstn, clk_en, supply_dip;
  logic        frame_start, bit_stb, data_in, data_out, data_oe, off_cmd, supply_loss_marker;
  logic        modulation_select, idle_stretch, noise_gate_en, poll_continuous, idle_permanent;
  logic [1:0]  rate_band_select;
  logic [3:0]  limit_scale_factor, check_bit_count;
  logic [4:0]  idle_code;
  logic [9:0]  lim_min_cyc, lim_max_cyc;
  logic [17:0] idle_cycles;
  logic [11:0] op_e, win_e, op;
  int          fail_count  = 0;
  int          check_count = 0;
  int          offs        = 0;
  int          offs_before;

  rcd_mcu_model mcu (.clk, .frame_start, .bit_stb, .data_in);

  rcd_config_decoder dut (.clk, .rstn, .clk_en, .frame_start, .bit_stb, .data_in, .supply_dip, .data_out,
    .data_oe, .off_cmd, .supply_loss_marker, .rate_band_select, .limit_scale_factor, .check_bit_count,
    .modulation_select, .idle_code, .idle_stretch, .noise_gate_en, .lim_min_cyc, .lim_max_cyc, .idle_cycles,
    .poll_continuous, .idle_permanent);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counts high cycles, so a clean pulse adds exactly one; sampled mid-cycle to stay clear of the launching edge
  always @(negedge clk) if (off_cmd === 1'b1) offs++;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // each step of the rate band halves the limit scale factor
  function automatic logic [3:0] exp_scale(input logic [1:0] band);
    return 4'h8 >> band;
  endfunction : exp_scale

  task automatic check_all;
    logic [3:0] sc;
    sc = exp_scale(op_e[11:10]);
    `CHK("band", op_e[11:10], rate_band_select)
    `CHK("scale", sc, limit_scale_factor)
    `CHK("count", 4'(op_e[9:8] * 3), check_bit_count)
    `CHK("modulation", op_e[7], modulation_select)
    `CHK("idle code", op_e[6:2], idle_code)
    `CHK("stretch", op_e[1], idle_stretch)
    `CHK("noise gate", op_e[0], noise_gate_en)
    `CHK("lower limit", 10'(win_e[11:6]) * sc, lim_min_cyc)
    `CHK("upper limit", 10'(win_e[5:0]) * sc, lim_max_cyc)
    `CHK("idle cycles", 18'(op_e[6:2] * (op_e[1] ? 8 : 1) * 1024), idle_cycles)
    `CHK("continuous", op_e[6:2] == 5'h00, poll_continuous)
    `CHK("permanent", op_e[6:2] == 5'h1F, idle_permanent)
  endtask : check_all

  task automatic wr(input logic sel, input logic [11:0] d, input logic stop);
    mcu.send({1'b0, sel, d, stop}, $urandom_range(2), 15);
    repeat (4) @(posedge clk);
    #1;
    if (!stop && sel) op_e = d;
    if (!stop && !sel) win_e = d;
  endtask : wr

  task automatic do_reset;
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    op_e  = {2'b00, 2'b01, 1'b0, 5'b00110, 1'b0, 1'b1};
    win_e = {6'b010101, 6'b101001};
    check_all;
    `CHK("marker", 1'b0, supply_loss_marker)
  endtask : do_reset

  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end

  initial begin
    clk_en     = 1'b1;
    supply_dip = 1'b0;
    void'($urandom(83));
    do_reset;
    // every band and count code, idle codes 0 and 31 included
    for (int i = 0; i < 8; i++) begin
      op = {2'(i), 2'(i >> 1), 8'($urandom)};
      if (i < 2) op[6:2] = (i == 1) ? 5'h1F : 5'h00;
      wr(1'b1, op, 1'b0);
      wr(1'b0, 12'($urandom), 1'b0);
      check_all;
    end
    wr(1'($urandom), 12'($urandom), 1'b1);
    check_all;
    offs_before = offs;
    mcu.send({1'b1, 14'($urandom)}, 0, 15);
    repeat (4) @(posedge clk);
    #1;
    `CHK("off pulses", offs_before + 1, offs)
    check_all;
    // abandoned word followed by a full one
    mcu.send({1'b0, 14'($urandom)}, 0, 7);
    wr(1'b0, 12'($urandom), 1'b0);
    check_all;
    clk_en = 1'b0;
    mcu.send({2'b01, 12'($urandom), 1'b0}, 0, 15);
    clk_en = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check_all;
    @(posedge clk);
    #1;
    supply_dip = 1'b1;
    @(posedge clk);
    #1;
    supply_dip = 1'b0;
    `CHK("marker", 1'b1, supply_loss_marker)
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      `CHK("marker drive", ~MARK_PATTERN[7 - i], data_oe)
    end
    `CHK("pin value", 1'b0, data_out)
    wr(1'b1, 12'($urandom), 1'b0);
    `CHK("marker", 1'b1, supply_loss_marker)
    wr(1'b0, 12'($urandom), 1'b0);
    `CHK("marker", 1'b0, supply_loss_marker)
    check_all;
    do_reset;
    print_verdict;
  end
endmodule : tb
